// File: shared/ifl_defines.svh
// Constants for the interrupt pending flag logic
`ifndef IFL_DEFINES_SVH
`define IFL_DEFINES_SVH

`define IFL_DATA_W 16
`define IFL_NUM_FLAGS 6
`define IFL_IDX_W 3
`define IFL_ADDR_FLAGS 16'h0006
`define IFL_FLAGS_RESET 6'h00
`define IFL_RESERVED_READ 10'h000
`define IFL_BIT_HOLD 0
`define IFL_BIT_EXT 1
`define IFL_BIT_TIMER 2
`define IFL_BIT_SYNC_RX 3
`define IFL_BIT_SYNC_TX 4
`define IFL_BIT_ASYNC 5
`define IFL_PIN_HOLD 0
`define IFL_PIN_B 1
`define IFL_PIN_C 2
`define IFL_NUM_PINS 3
`define IFL_PIN_IDLE 1'b1

`endif

// File: shared/ifl_pkg.sv
// Types shared by the interrupt pending flag logic
package ifl_pkg;

    typedef struct packed {
        logic async_serial_txrx_irq;
        logic sync_serial_tx_irq;
        logic sync_serial_rx_irq;
        logic timer_irq;
    } ifl_periph_req_type;

    typedef struct packed {
        logic hold_mode;
        logic mask_b;
        logic mask_c;
    } ifl_ctl_type;

    typedef struct packed {
        logic [2:0] prev;
        logic [2:0] fall;
        logic [2:0] rise;
    } ifl_edge_state_type;

    typedef struct packed {
        logic [5:0] flags;
        logic second_pin_flag;
        logic third_pin_flag;
        logic [15:0] rdata;
        logic req;
        logic [2:0] req_idx;
    } ifl_state_type;

endpackage : ifl_pkg

// File: logic/ifl_edge_detect.sv
// Edge detector for the active-low external interrupt pins
`timescale 1ns/1ps
`include "ifl_defines.svh"
module ifl_edge_detect
    import ifl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] pin_i,
    output logic [2:0] fall_o,
    output logic [2:0] rise_o
);
    ifl_edge_state_type state_q;
    ifl_edge_state_type state_d;

    // Idle level preset avoids a false edge when a pin sits high at reset
    always_comb begin
        state_d = state_q;
        state_d.prev = pin_i;
        state_d.fall = state_q.prev & ~pin_i;
        state_d.rise = ~state_q.prev & pin_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q.prev <= {`IFL_NUM_PINS{`IFL_PIN_IDLE}};
            state_q.fall <= '0;
            state_q.rise <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign fall_o = state_q.fall;
    assign rise_o = state_q.rise;
endmodule : ifl_edge_detect

// File: logic/ifl_flag_reg.sv
// Interrupt pending flag register with shared external flag and request gating
// What this block does
// R1 - A request reaching the CPU sets its bit in the flag word at 0006h.
// R2 - Writing 1 clears a flag bit; writing 0 leaves it unchanged.
// R3 - Writing back the value just read clears all flags then pending.
// R4 - A hardware acknowledge clears the matching flag bit.
// R5 - Reset clears every flag bit.
// R6 - Entry by the vector call instruction leaves the flag set.
// R7 - Bits 15 to 6 read as zero; writes to them do nothing.
// R8 - Bit 5 is the async serial transmit/receive pending flag.
// R9 - Bit 4 is sync serial transmit, bit 3 sync serial receive.
// R10 - Bit 2 is the timer pending flag.
// R11 - Request b sets shared bit 1 and the second pin flag together.
// R12 - Request c sets shared bit 1 and the third pin flag together.
// R13 - Pin flags survive acknowledge; only a software clear or reset removes them.
// R14 - Mode 1: only a falling edge on the hold pin sets bit 0.
// R15 - Mode 0: both edges on the hold pin set bit 0.
// R16 - Reading the flag word returns every current pending flag.
// R17 - Serial service routines should clear flags just before returning.
// R18 - Requests b and c count only when their own mask bit allows.
// R19 - A flag is set whether or not it is later acknowledged.
// R20 - Pending leads to a request only if unmasked and not globally disabled.
// R21 - A set in the same cycle as a clear wins.
`timescale 1ns/1ps
`include "ifl_defines.svh"
module ifl_flag_reg
    import ifl_pkg::*;
#(
    parameter int DATA_W = `IFL_DATA_W,
    parameter int NUM_FLAGS = `IFL_NUM_FLAGS
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] dm_addr_i,
    input wire logic dm_wr_i,
    input wire logic dm_rd_i,
    input wire logic [DATA_W-1:0] dm_wdata_i,
    output logic [DATA_W-1:0] dm_rdata_o,
    input wire ifl_periph_req_type periph_req_i,
    input wire logic hold_or_first_external_irq_n_i,
    input wire logic external_request_b_n_i,
    input wire logic external_request_c_n_i,
    input wire ifl_ctl_type ctl_i,
    input wire logic [1:0] pin_flag_clr_i,
    input wire logic [NUM_FLAGS-1:0] irq_mask_register_i,
    input wire logic global_irq_disable_i,
    input wire logic ack_i,
    input wire logic [2:0] ack_sel_i,
    input wire logic ack_from_vector_call_i,
    output logic [NUM_FLAGS-1:0] interrupt_flag_register_o,
    output logic second_pin_flag_o,
    output logic third_pin_flag_o,
    output logic cpu_irq_req_o,
    output logic [2:0] cpu_irq_idx_o
);
    ifl_state_type state_q;
    ifl_state_type state_d;
    logic [2:0] pin_fall;
    logic [2:0] pin_rise;
    logic [NUM_FLAGS-1:0] set_v;
    logic [NUM_FLAGS-1:0] sw_clr_v;
    logic [NUM_FLAGS-1:0] ack_clr_v;
    logic [NUM_FLAGS-1:0] enabled_v;
    logic hit;
    logic ext_b_ok;
    logic ext_c_ok;

    // Edges show one cycle after the pin moves; pins are synchronous inputs
    ifl_edge_detect u_edge (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i({external_request_c_n_i, external_request_b_n_i,
                hold_or_first_external_irq_n_i}),
        .fall_o(pin_fall),
        .rise_o(pin_rise)
    );

    assign hit = dm_addr_i == `IFL_ADDR_FLAGS;
    assign ext_b_ok = pin_fall[`IFL_PIN_B] & ctl_i.mask_b; // R18
    assign ext_c_ok = pin_fall[`IFL_PIN_C] & ctl_i.mask_c; // R18

    always_comb begin
        // Sets ignore irq_mask_register_i (only mask_b and mask_c gate pins b and c): pending is recorded even if never acknowledged
        set_v = '0; // R19
        set_v[`IFL_BIT_ASYNC] = periph_req_i.async_serial_txrx_irq; // R8
        set_v[`IFL_BIT_SYNC_TX] = periph_req_i.sync_serial_tx_irq; // R9
        set_v[`IFL_BIT_SYNC_RX] = periph_req_i.sync_serial_rx_irq; // R9
        set_v[`IFL_BIT_TIMER] = periph_req_i.timer_irq; // R10
        set_v[`IFL_BIT_EXT] = ext_b_ok | ext_c_ok; // R11 R12
        set_v[`IFL_BIT_HOLD] = pin_fall[`IFL_PIN_HOLD] |
            (pin_rise[`IFL_PIN_HOLD] & ~ctl_i.hold_mode); // R14 R15
    end

    // Only the implemented low bits are looked at; upper write bits fall away R7
    assign sw_clr_v = (dm_wr_i && hit) ? dm_wdata_i[NUM_FLAGS-1:0] : '0; // R2 R3

    // Vector call entry must not drop the flag: software owns that clear
    genvar g;
    generate
        for (g = 0; g < NUM_FLAGS; g++) begin : g_ack
            assign ack_clr_v[g] = ack_i && !ack_from_vector_call_i &&
                (ack_sel_i == 3'(g)); // R4 R6
        end
    endgenerate

    assign enabled_v = state_q.flags & irq_mask_register_i &
        {NUM_FLAGS{~global_irq_disable_i}}; // R20

    always_comb begin
        state_d = state_q;
        // Set overrides both clears so a request landing on a clear is kept
        state_d.flags = (state_q.flags & ~(sw_clr_v | ack_clr_v)) | set_v; // R1 R21
        // Pin flags ignore acknowledge; a clear strobe or reset is the only way out
        state_d.second_pin_flag = (state_q.second_pin_flag & ~pin_flag_clr_i[0]) |
            ext_b_ok; // R11 R13 R21
        state_d.third_pin_flag = (state_q.third_pin_flag & ~pin_flag_clr_i[1]) |
            ext_c_ok; // R12 R13 R21
        state_d.rdata = '0;
        if (dm_rd_i && hit) begin
            state_d.rdata = {`IFL_RESERVED_READ, state_q.flags}; // R7 R16
        end
        // Lowest bit number has the highest priority
        state_d.req = |enabled_v; // R20
        state_d.req_idx = '0;
        for (int i = NUM_FLAGS - 1; i >= 0; i--) begin
            if (enabled_v[i]) begin
                state_d.req_idx = 3'(i);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= '0; // R5
        end else begin
            state_q <= state_d;
        end
    end

    assign dm_rdata_o = state_q.rdata;
    assign interrupt_flag_register_o = state_q.flags;
    assign second_pin_flag_o = state_q.second_pin_flag;
    assign third_pin_flag_o = state_q.third_pin_flag;
    assign cpu_irq_req_o = state_q.req;
    assign cpu_irq_idx_o = state_q.req_idx;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    timer_sets_a: assert property ( // R1
        periph_req_i.timer_irq |=> interrupt_flag_register_o[`IFL_BIT_TIMER]
    ) else $error("timer request did not set its flag");

    async_sets_a: assert property ( // R8
        periph_req_i.async_serial_txrx_irq |=> interrupt_flag_register_o[`IFL_BIT_ASYNC]
    ) else $error("async serial request did not set bit 5");

    sync_rx_sets_a: assert property ( // R9
        periph_req_i.sync_serial_rx_irq ##1 !periph_req_i.sync_serial_rx_irq
        |-> interrupt_flag_register_o[`IFL_BIT_SYNC_RX]
    ) else $error("sync receive request did not set bit 3");

    w1c_clears_a: assert property ( // R2
        dm_wr_i && hit && dm_wdata_i[`IFL_BIT_SYNC_TX] && !set_v[`IFL_BIT_SYNC_TX]
        |=> !interrupt_flag_register_o[`IFL_BIT_SYNC_TX]
    ) else $error("write of one did not clear bit 4");

    zero_keeps_a: assert property ( // R2
        dm_wr_i && hit && !dm_wdata_i[`IFL_BIT_TIMER] && !ack_clr_v[`IFL_BIT_TIMER]
        && interrupt_flag_register_o[`IFL_BIT_TIMER]
        |=> interrupt_flag_register_o[`IFL_BIT_TIMER]
    ) else $error("write of zero changed a flag");

    write_back_a: assert property ( // R3
        dm_wr_i && hit && dm_wdata_i[NUM_FLAGS-1:0] == interrupt_flag_register_o
        && set_v == '0
        |=> (interrupt_flag_register_o & $past(interrupt_flag_register_o)) == '0
    ) else $error("writing back the read value left a flag pending");

    set_wins_a: assert property ( // R21
        dm_wr_i && hit && dm_wdata_i[`IFL_BIT_TIMER] && periph_req_i.timer_irq
        |=> interrupt_flag_register_o[`IFL_BIT_TIMER]
    ) else $error("a clear beat a simultaneous set");

    ack_clears_a: assert property ( // R4
        ack_i && !ack_from_vector_call_i && ack_sel_i == 3'(`IFL_BIT_TIMER)
        && !periph_req_i.timer_irq
        |=> !interrupt_flag_register_o[`IFL_BIT_TIMER]
    ) else $error("hardware acknowledge did not clear its flag");

    vcall_keeps_a: assert property ( // R6
        ack_i && ack_from_vector_call_i && !dm_wr_i
        && interrupt_flag_register_o[`IFL_BIT_TIMER]
        |=> interrupt_flag_register_o[`IFL_BIT_TIMER]
    ) else $error("vector call entry cleared a flag");

    reset_clears_a: assert property ( // R5
        @(posedge core_clk_i) disable iff (1'b0) rst_i |=> interrupt_flag_register_o == '0
    ) else $error("reset left a flag set");

    read_value_a: assert property ( // R16
        dm_rd_i && hit
        |=> dm_rdata_o[NUM_FLAGS-1:0] == $past(interrupt_flag_register_o)
    ) else $error("read returned the wrong flags");

    reserved_zero_a: assert property ( // R7
        dm_rd_i |=> dm_rdata_o[DATA_W-1:NUM_FLAGS] == '0
    ) else $error("reserved bits did not read zero");

    pin_b_sets_a: assert property ( // R11
        pin_fall[`IFL_PIN_B] && ctl_i.mask_b
        |=> interrupt_flag_register_o[`IFL_BIT_EXT] && second_pin_flag_o
    ) else $error("request b did not set both flags");

    pin_c_sets_a: assert property ( // R12
        $fell(external_request_c_n_i) ##1 ctl_i.mask_c
        |=> interrupt_flag_register_o[`IFL_BIT_EXT] && third_pin_flag_o
    ) else $error("request c did not set both flags");

    pin_masked_a: assert property ( // R18
        pin_fall[`IFL_PIN_B] && !ctl_i.mask_b |=> !$rose(second_pin_flag_o)
    ) else $error("masked request b set its pin flag");

    pin_flag_keep_a: assert property ( // R13
        ack_i && ack_sel_i == 3'(`IFL_BIT_EXT) && second_pin_flag_o
        && !pin_flag_clr_i[0]
        |=> second_pin_flag_o
    ) else $error("acknowledge cleared the second pin flag");

    hold_neg_only_a: assert property ( // R14
        pin_rise[`IFL_PIN_HOLD] && ctl_i.hold_mode
        |=> !$rose(interrupt_flag_register_o[`IFL_BIT_HOLD])
    ) else $error("rising edge set bit 0 in mode 1");

    hold_both_a: assert property ( // R15
        pin_rise[`IFL_PIN_HOLD] && !ctl_i.hold_mode
        |=> interrupt_flag_register_o[`IFL_BIT_HOLD]
    ) else $error("rising edge missed bit 0 in mode 0");

    req_gated_a: assert property ( // R20
        cpu_irq_req_o |-> $past(!global_irq_disable_i)
            && ($past(irq_mask_register_i) & $past(interrupt_flag_register_o)) != '0
    ) else $error("request raised while masked or disabled");

    sync_tx_sets_a: assert property ( // R9
        periph_req_i.sync_serial_tx_irq |=> interrupt_flag_register_o[`IFL_BIT_SYNC_TX]
    ) else $error("sync transmit request did not set bit 4");

    sync_rx_cause_a: assert property ( // R9
        $rose(interrupt_flag_register_o[`IFL_BIT_SYNC_RX])
        |-> $past(periph_req_i.sync_serial_rx_irq)
    ) else $error("bit 3 rose with no sync receive request");

    hold_fall_sets_a: assert property ( // R14
        pin_fall[`IFL_PIN_HOLD] |=> interrupt_flag_register_o[`IFL_BIT_HOLD]
    ) else $error("falling edge on the hold pin missed bit 0");

    hold_cause_a: assert property ( // R15
        $rose(interrupt_flag_register_o[`IFL_BIT_HOLD])
        |-> $past(pin_fall[`IFL_PIN_HOLD] || pin_rise[`IFL_PIN_HOLD])
    ) else $error("bit 0 rose with no pin edge");

    pin_c_masked_a: assert property ( // R18
        pin_fall[`IFL_PIN_C] && !ctl_i.mask_c |=> !$rose(third_pin_flag_o)
    ) else $error("masked request c set its pin flag");

    shared_cause_a: assert property ( // R11
        $rose(interrupt_flag_register_o[`IFL_BIT_EXT]) |-> $past(ext_b_ok || ext_c_ok)
    ) else $error("shared bit rose with no unmasked pin request");

    pin_b_cause_a: assert property ( // R11
        $rose(second_pin_flag_o) |-> $past(ext_b_ok)
    ) else $error("second pin flag rose with no request b");

    pin_c_cause_a: assert property ( // R12
        $rose(third_pin_flag_o) |-> $past(ext_c_ok)
    ) else $error("third pin flag rose with no request c");

    third_keep_a: assert property ( // R13
        ack_i && ack_sel_i == 3'(`IFL_BIT_EXT) && third_pin_flag_o
        && !pin_flag_clr_i[1]
        |=> third_pin_flag_o
    ) else $error("acknowledge cleared the third pin flag");

    second_clr_a: assert property ( // R13
        pin_flag_clr_i[0] && !ext_b_ok |=> !second_pin_flag_o
    ) else $error("clear strobe left the second pin flag set");

    third_clr_a: assert property ( // R13
        pin_flag_clr_i[1] && !ext_c_ok |=> !third_pin_flag_o
    ) else $error("clear strobe left the third pin flag set");

    timer_cause_a: assert property ( // R10
        $rose(interrupt_flag_register_o[`IFL_BIT_TIMER]) |-> $past(periph_req_i.timer_irq)
    ) else $error("timer flag rose with no timer request");

    async_cause_a: assert property ( // R8
        $rose(interrupt_flag_register_o[`IFL_BIT_ASYNC])
        |-> $past(periph_req_i.async_serial_txrx_irq)
    ) else $error("bit 5 rose with no async serial request");

    w1c_async_a: assert property ( // R2
        dm_wr_i && hit && dm_wdata_i[`IFL_BIT_ASYNC]
        && !set_v[`IFL_BIT_ASYNC]
        |=> !interrupt_flag_register_o[`IFL_BIT_ASYNC]
    ) else $error("write of one did not clear bit 5");

    ack_others_a: assert property ( // R4
        ack_i && !ack_from_vector_call_i && ack_sel_i == 3'(`IFL_BIT_EXT)
        && !(dm_wr_i && hit)
        |=> !$fell(interrupt_flag_register_o[`IFL_BIT_TIMER])
    ) else $error("acknowledge of bit 1 cleared the timer flag");

    vcall_all_keep_a: assert property ( // R6
        ack_i && ack_from_vector_call_i && !(dm_wr_i && hit)
        |=> (interrupt_flag_register_o & $past(interrupt_flag_register_o))
            == $past(interrupt_flag_register_o)
    ) else $error("vector call entry dropped a pending flag");

    idle_read_zero_a: assert property ( // R16
        !(dm_rd_i && hit) |=> dm_rdata_o == '0
    ) else $error("read data stood without a read");

    req_follows_a: assert property ( // R20
        enabled_v != '0 |=> cpu_irq_req_o
    ) else $error("enabled flag raised no request");

    timer_first_a: assert property ( // R20
        enabled_v[`IFL_BIT_TIMER] && !enabled_v[`IFL_BIT_EXT] && !enabled_v[`IFL_BIT_HOLD]
        |=> cpu_irq_idx_o == 3'(`IFL_BIT_TIMER)
    ) else $error("timer not chosen as highest pending");

    idle_idx_a: assert property ( // R20
        !cpu_irq_req_o |-> cpu_irq_idx_o == '0
    ) else $error("index shown without a request");

    disable_blocks_a: assert property ( // R20
        global_irq_disable_i |=> !cpu_irq_req_o
    ) else $error("request raised while globally disabled");

    reset_outputs_a: assert property ( // R5
        @(posedge core_clk_i) disable iff (1'b0)
        rst_i |=> !second_pin_flag_o && !third_pin_flag_o && !cpu_irq_req_o
    ) else $error("reset left a pin flag or request set");

endmodule : ifl_flag_reg

// File: sim/ifl_far_model.sv
// Far side model: peripheral request lines and the three active-low pins
`timescale 1ns/1ps
module ifl_far_model
    import ifl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] pin_low_i,
    input wire logic [3:0] fire_i,
    output logic [2:0] pin_n_o,
    output ifl_periph_req_type req_o
);
    // Pins sit idle high through reset so release never shows a false edge
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_n_o <= 3'h7;
            req_o <= ifl_periph_req_type'(4'h0);
        end else begin
            pin_n_o <= ~pin_low_i;
            req_o <= ifl_periph_req_type'(fire_i);
        end
    end
endmodule : ifl_far_model

// File: sim/tb_top.sv
// Self-checking bench for the interrupt pending flag register
`timescale 1ns/1ps
module tb_top;
    import ifl_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic dm_wr = 1'b0;
    logic dm_rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    ifl_periph_req_type preq;
    logic [2:0] pins_n;
    logic [2:0] pin_low = 3'h0;
    logic [3:0] fire = 4'h0;
    logic [2:0] ctl = 3'h6;
    logic [1:0] pclr = 2'h0;
    logic gdis = 1'b0;
    logic ack = 1'b0;
    logic [2:0] sel = 3'h0;
    logic vec = 1'b0;
    logic [5:0] flags;
    logic f2, f3, irq;
    logic [2:0] idx;
    logic [17:0] notes[$];
    logic rd_q = 1'b0;
    logic [5:0] imask = 6'h3F;
    logic [17:0] note_v;
    logic [5:0] ef = 6'h00;
    logic e2 = 1'b0;
    logic e3 = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 39961;
    logic [15:0] rnd;
    initial forever #2.5 core_clk_i = ~core_clk_i;
    ifl_far_model far (.core_clk_i(core_clk_i), .rst_i(rst_i), .pin_low_i(pin_low),
        .fire_i(fire), .pin_n_o(pins_n), .req_o(preq));
    ifl_flag_reg dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .dm_addr_i(addr),
        .dm_wr_i(dm_wr), .dm_rd_i(dm_rd), .dm_wdata_i(wdata), .dm_rdata_o(rdata),
        .periph_req_i(preq), .hold_or_first_external_irq_n_i(pins_n[0]),
        .external_request_b_n_i(pins_n[1]), .external_request_c_n_i(pins_n[2]),
        .ctl_i(ifl_ctl_type'(ctl)), .pin_flag_clr_i(pclr), .irq_mask_register_i(imask),
        .global_irq_disable_i(gdis), .ack_i(ack), .ack_sel_i(sel),
        .ack_from_vector_call_i(vec), .interrupt_flag_register_o(flags),
        .second_pin_flag_o(f2), .third_pin_flag_o(f3), .cpu_irq_req_o(irq),
        .cpu_irq_idx_o(idx));
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Read data stands one cycle only, so the watcher samples it mid-cycle
    always @(posedge core_clk_i) rd_q <= dm_rd;
    always @(negedge core_clk_i) begin
        if (rd_q) begin
            note_v = notes.pop_front();
            chk("read word", note_v, {rdata, f2, f3});
            chk("flag output", {12'h000, note_v[7:2]}, {12'h000, flags});
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    task automatic rd_w(input logic [15:0] a);
        @(posedge core_clk_i);
        dm_rd <= 1'b1;
        addr <= a;
        notes.push_back((a == 16'h0006) ? {10'h000, ef, e2, e3} : {16'h0000, e2, e3});
        @(posedge core_clk_i);
        dm_rd <= 1'b0;
        tick(3);
    endtask : rd_w
    task automatic wr_w(input logic [15:0] d);
        @(posedge core_clk_i);
        dm_wr <= 1'b1;
        addr <= 16'h0006;
        wdata <= d;
        ef = ef & ~d[5:0];
        @(posedge core_clk_i);
        dm_wr <= 1'b0;
        tick(2);
    endtask : wr_w
    task automatic fire_w(input logic [3:0] f);
        @(posedge core_clk_i);
        fire <= f;
        @(posedge core_clk_i);
        fire <= 4'h0;
        ef = ef | {f, 2'b00};
        tick(3);
    endtask : fire_w
    task automatic pin_w(input int p, input logic low);
        @(posedge core_clk_i);
        pin_low[p] <= low;
        tick(4);
    endtask : pin_w
    task automatic ack_w(input logic [2:0] s, input logic v);
        @(posedge core_clk_i);
        ack <= 1'b1;
        sel <= s;
        vec <= v;
        @(posedge core_clk_i);
        ack <= 1'b0;
        vec <= 1'b0;
        ef[s] = ef[s] & v;
        tick(2);
    endtask : ack_w
    task automatic pclr_w(input logic [1:0] c);
        @(posedge core_clk_i);
        pclr <= c;
        @(posedge core_clk_i);
        pclr <= 2'h0;
        tick(2);
    endtask : pclr_w
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        $display("Error run time limit expected end seen hang");
        final_report();
    end
    initial begin
        tick(12);
        rst_i <= 1'b0;
        tick(2);
        rd_w(16'h0006);
        rd_w(16'h0004);
        for (int i = 0; i < 4; i++) begin
            fire_w(4'h1 << i);
            rd_w(16'h0006);
        end
        @(negedge core_clk_i);
        chk("irq request", {14'h0, 1'b1, 3'h2}, {14'h0, irq, idx});
        @(posedge core_clk_i);
        gdis <= 1'b1;
        tick(3);
        @(negedge core_clk_i);
        chk("irq disabled", 18'h0, {17'h0, irq});
        @(posedge core_clk_i);
        gdis <= 1'b0;
        imask <= 6'h30;
        tick(3);
        @(negedge core_clk_i);
        chk("irq masked", {14'h0, 1'b1, 3'h4}, {14'h0, irq, idx});
        @(posedge core_clk_i);
        imask <= 6'h3F;
        ack_w(3'h2, 1'b1);
        rd_w(16'h0006);
        ack_w(3'h2, 1'b0);
        rd_w(16'h0006);
        for (int i = 0; i < 4; i++) begin
            fire_w(4'hF);
            rnd = 16'($random(seed));
            wr_w(rnd);
            rd_w(16'h0006);
        end
        wr_w({10'h000, ef});
        rd_w(16'h0006);
        $display("test flag word done");
        fire_w(4'h1);
        @(posedge core_clk_i);
        fire <= 4'h1;
        @(posedge core_clk_i);
        fire <= 4'h0;
        dm_wr <= 1'b1;
        wdata <= 16'h0004;
        @(posedge core_clk_i);
        dm_wr <= 1'b0;
        tick(3);
        rd_w(16'h0006);
        $display("test set wins done");
        pin_w(1, 1'b1);
        ef[1] = 1'b1;
        e2 = 1'b1;
        rd_w(16'h0006);
        ack_w(3'h1, 1'b0);
        rd_w(16'h0006);
        pclr_w(2'h1);
        e2 = 1'b0;
        pin_w(1, 1'b0);
        pin_w(2, 1'b1);
        rd_w(16'h0006);
        pin_w(2, 1'b0);
        ctl <= 3'h7;
        pin_w(2, 1'b1);
        ef[1] = 1'b1;
        e3 = 1'b1;
        rd_w(16'h0006);
        wr_w(16'h0002);
        pclr_w(2'h2);
        e3 = 1'b0;
        pin_w(2, 1'b0);
        rd_w(16'h0006);
        $display("test shared pins done");
        pin_w(0, 1'b1);
        ef[0] = 1'b1;
        rd_w(16'h0006);
        wr_w(16'h0001);
        pin_w(0, 1'b0);
        rd_w(16'h0006);
        ctl <= 3'h3;
        pin_w(0, 1'b1);
        wr_w(16'h0001);
        pin_w(0, 1'b0);
        ef[0] = 1'b1;
        rd_w(16'h0006);
        $display("test hold pin done");
        fire_w(4'hF);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        ef = 6'h00;
        tick(2);
        rd_w(16'h0006);
        $display("test reset done");
        if (notes.size() != 0) begin
            fail_count++;
            $display("Error pending notes expected 0 seen %0d", notes.size());
        end
        final_report();
    end
endmodule : tb_top
